// ===== shared/sec_params.svh
// constants for the serial eeprom command logic
// Operation
// - select falls, opcode first, MSB first
// - X110 sets latch, X100 clears it
// - A011 reads array, A010 writes it
// - X101 reads status, X001 loads protect bits
// - latch clear at reset; set before writes
// - latch set only while protect pin high
// - latch clear works regardless of protect pin
// - status: busy, latch, protect lo, hi
// - upper bits zero idle, all ones busy
// - protect bits pick quarter, half, all
// - protect bits need latch, full cycle
// - protected addresses are never programmed
// - read: opcode, address, then data out
// - read auto-increments and wraps to zero
// - programming starts after select rises
// - busy: only status read is honoured
// - page write wraps low three bits
// - completed write clears the latch
// - write discarded if protected or latch clear
// - undefined opcode: ignore until next select
// - protect low in frame aborts pending write
// - hold pauses transfer, output floats
// - deselected: no input, output floats
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH
`define SEC_OP_SET_LATCH   3'h6
`define SEC_OP_CLR_LATCH   3'h4
`define SEC_OP_RD_STATUS   3'h5
`define SEC_OP_WR_STATUS   3'h1
`define SEC_OP_READ        3'h3
`define SEC_OP_WRITE       3'h2
`define SEC_ST_BUSY        0
`define SEC_ST_LATCH       1
`define SEC_ST_BP_LO       2
`define SEC_ST_BP_HI       3
`define SEC_BP_RESET       2'h0
`define SEC_WRITE_NS       5000000
`define SEC_CLK_NS         20
`define SEC_WRITE_CYC      (`SEC_WRITE_NS / `SEC_CLK_NS)
`define SEC_ADDR_W         9
`define SEC_PAGE_BYTES     8
`endif

// ===== shared/sec_pkg.sv
// types for the serial eeprom command logic
package sec_pkg;
	typedef enum logic [2:0] {
		SEC_OPC,
		SEC_ADR,
		SEC_RDATA,
		SEC_WDATA,
		SEC_STAT,
		SEC_SREG,
		SEC_DEAD
	} sec_phase_e;
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic wp_n;
		logic hold_n;
	} sec_pins_s;
endpackage

// ===== rtl/sec_eeprom.sv
// spi serial eeprom command logic, device side
`timescale 1ns/1ps
`default_nettype none
`include "sec_params.svh"
module sec_eeprom import sec_pkg::*; #(
	parameter int WRITE_CYC = `SEC_WRITE_CYC
) (
	// clock and reset
	input  wire logic      ref_clk,
	input  wire logic      arst_n,
	// serial link pins
	input  wire sec_pins_s pins,
	output logic           so_out,
	output logic           so_oe_n,
	// status view
	output logic           busy
);
	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	sec_pins_s meta_ff;
	sec_pins_s sync_ff;
	logic      sck_d_ff;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff  <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
			sync_ff  <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
			sck_d_ff <= 1'b0;
		end else begin
			meta_ff  <= pins;
			sync_ff  <= meta_ff;
			sck_d_ff <= sync_ff.sck;
		end
	end

	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	logic       cs_d_ff;
	logic       hold_ff;
	logic [7:0] mem [0:(1 << `SEC_ADDR_W) - 1];
	logic [7:0] sh_ff;
	logic [2:0] cnt_ff;
	logic [8:0] adr_ff;
	logic [7:0] dout_ff;
	logic [1:0] bp_ff;
	logic [1:0] bp_new_ff;
	logic       latch_ff;
	logic       pend_ff;
	logic       pend_sr_ff;
	logic [7:0] page_ff [0:`SEC_PAGE_BYTES - 1];
	logic [7:0] pmask_ff;
	logic [31:0] tmr_ff;
	sec_phase_e ph_ff;
	logic       is_wr_ff;
	// the page buffer holds data until select rises; a frame cut mid byte still programs the bytes it completed

	wire       sel        = !sync_ff.cs_n;
	wire       cs_fall    = cs_d_ff && sync_ff.cs_n == 1'b0;
	wire       cs_rise    = !cs_d_ff && sync_ff.cs_n;
	// hold is taken only while the clock is low, and released while the clock is low or at once on deselect
	wire       nxt_hold   = sync_ff.sck ? hold_ff : !sync_ff.hold_n;
	wire       active     = sel && !hold_ff;
	wire       sck_rise   = active && sync_ff.sck && !sck_d_ff;
	wire       sck_fall   = active && !sync_ff.sck && sck_d_ff;
	wire [7:0] nxt_byte   = {sh_ff[6:0], sync_ff.si};
	wire       byte_done  = sck_rise && cnt_ff == 3'h7;

	function automatic logic is_protected(input logic [1:0] bp, input logic [8:0] a);
		case (bp)
			2'h1:    is_protected = a[8:7] == 2'h3;
			2'h2:    is_protected = a[8];
			2'h3:    is_protected = 1'b1;
			default: is_protected = 1'b0;
		endcase
	endfunction

	wire [7:0] status = busy ? 8'hFF : {4'h0, bp_ff, latch_ff, 1'b0};

	// -----------------------------------------------------------------
	// serial front end
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_d_ff    <= 1'b1;
			hold_ff    <= 1'b0;
			sh_ff      <= 8'h00;
			cnt_ff     <= 3'h0;
			adr_ff     <= 9'h000;
			ph_ff      <= SEC_OPC;
			latch_ff   <= 1'b0;
			pend_ff    <= 1'b0;
			pend_sr_ff <= 1'b0;
			pmask_ff   <= 8'h00;
			bp_new_ff  <= 2'h0;
			dout_ff    <= 8'h00;
			so_out     <= 1'b0;
			so_oe_n    <= 1'b1;
			busy       <= 1'b0;
			tmr_ff     <= 32'h0;
			bp_ff      <= `SEC_BP_RESET;
		end else begin
			cs_d_ff <= sync_ff.cs_n;
			hold_ff <= sel ? nxt_hold : 1'b0;
			// output floats when deselected, on hold or outside a read
			so_oe_n <= !(active && (ph_ff == SEC_RDATA || ph_ff == SEC_STAT));
			if (cs_fall) begin
				cnt_ff   <= 3'h0;
				ph_ff    <= SEC_OPC;
				pmask_ff <= 8'h00;
				pend_ff  <= 1'b0;
			end
			if (sck_rise) begin
				sh_ff  <= nxt_byte;
				cnt_ff <= cnt_ff + 3'h1;
			end
			if (sel && !sync_ff.wp_n) begin
				pend_ff <= 1'b0;
			end
			if (byte_done) begin
				case (ph_ff)
				SEC_OPC: begin
					adr_ff[8] <= nxt_byte[3];
					if (nxt_byte[7:4] != 4'h0) begin
						ph_ff <= SEC_DEAD;
					end else if (busy) begin
						ph_ff <= nxt_byte[2:0] == `SEC_OP_RD_STATUS ? SEC_STAT : SEC_DEAD;
					end else begin
						case (nxt_byte[2:0])
						`SEC_OP_SET_LATCH: begin
							if (sync_ff.wp_n) latch_ff <= 1'b1;
							ph_ff <= SEC_DEAD;
						end
						`SEC_OP_CLR_LATCH: begin
							latch_ff <= 1'b0;
							ph_ff    <= SEC_DEAD;
						end
						`SEC_OP_RD_STATUS: ph_ff <= SEC_STAT;
						`SEC_OP_WR_STATUS: ph_ff <= SEC_SREG;
						`SEC_OP_READ:      ph_ff <= SEC_ADR;
						`SEC_OP_WRITE:     ph_ff <= SEC_ADR;
						default:           ph_ff <= SEC_DEAD;
						endcase
						pend_sr_ff <= nxt_byte[2:0] == `SEC_OP_WR_STATUS;
					end
				end
				SEC_ADR: begin
					adr_ff[7:0] <= nxt_byte;
					// the opcode byte already chose between data in and data out
					ph_ff <= is_wr_ff ? SEC_WDATA : SEC_RDATA;
				end
				SEC_WDATA: begin
					if (latch_ff && sync_ff.wp_n) pend_ff <= 1'b1;
					page_ff[adr_ff[2:0]]  <= nxt_byte;
					pmask_ff[adr_ff[2:0]] <= 1'b1;
					adr_ff[2:0] <= adr_ff[2:0] + 3'h1;
				end
				SEC_SREG: begin
					bp_new_ff <= nxt_byte[3:2];
					if (latch_ff && sync_ff.wp_n) pend_ff <= 1'b1;
					ph_ff <= SEC_DEAD;
				end
				SEC_RDATA: adr_ff <= adr_ff + 9'h001;
				default: ;
				endcase
			end
			// shift out on falling clock; load byte at the first bit
			if (sck_fall && cnt_ff == 3'h0) begin
				dout_ff <= ph_ff == SEC_STAT ? status : mem[adr_ff];
				so_out  <= ph_ff == SEC_STAT ? status[7] : mem[adr_ff][7];
			end else if (sck_fall) begin
				so_out <= dout_ff[3'h7 - cnt_ff];
			end
			// start programming only at select rising, never mid frame
			if (cs_rise && pend_ff && !busy) begin
				busy    <= 1'b1;
				tmr_ff  <= 32'(WRITE_CYC);
				pend_ff <= 1'b0;
				if (pend_sr_ff) bp_ff <= bp_new_ff;
			end else if (busy) begin
				if (tmr_ff <= 32'h1) begin
					busy     <= 1'b0;
					latch_ff <= 1'b0;
				end else begin
					tmr_ff <= tmr_ff - 32'h1;
				end
			end
		end
	end

	// separate write phase selection: write opcode goes to data bytes
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			is_wr_ff <= 1'b0;
		end else if (byte_done && ph_ff == SEC_OPC) begin
			is_wr_ff <= nxt_byte[2:0] == `SEC_OP_WRITE;
		end
	end

	// -----------------------------------------------------------------
	// array programming, every loaded unprotected byte of the page in one clock at cycle start
	// -----------------------------------------------------------------
	logic [8:0] base_ff;
	always_ff @(posedge ref_clk) begin
		if (cs_rise && pend_ff && !busy && !pend_sr_ff) begin
			for (int i = 0; i < `SEC_PAGE_BYTES; i++) begin
				if (pmask_ff[i] && !is_protected(bp_ff, {base_ff[8:3], 3'(i)})) begin
					mem[{base_ff[8:3], 3'(i)}] <= page_ff[i];
				end
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (byte_done && ph_ff == SEC_ADR) base_ff <= {adr_ff[8], nxt_byte};
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	// counts cycles of the running write; its full length is too long for a repetition
	logic [31:0] busy_cnt_ff;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_cnt_ff <= 32'h0;
		end else if (busy) begin
			busy_cnt_ff <= busy_cnt_ff + 32'h1;
		end else begin
			busy_cnt_ff <= 32'h0;
		end
	end

	// any opcode byte completing with a zero upper nibble
	sequence s_opcode_done;
		byte_done && ph_ff == SEC_OPC && nxt_byte[7:4] == 4'h0;
	endsequence

	// latch-set opcode on an idle device while the protect pin is low
	sequence s_set_while_wp;
		s_opcode_done ##0 (nxt_byte[2:0] == `SEC_OP_SET_LATCH && !busy && !sync_ff.wp_n);
	endsequence

	// latch-clear opcode on an idle device
	sequence s_clear_op;
		s_opcode_done ##0 (nxt_byte[2:0] == `SEC_OP_CLR_LATCH && !busy);
	endsequence

	// any opcode but the status read while a write cycle runs
	sequence s_op_while_busy;
		s_opcode_done ##0 (busy && nxt_byte[2:0] != `SEC_OP_RD_STATUS);
	endsequence

	// a running write must show all ones on the status byte
	chk_busy_status: assert property (@(posedge ref_clk) disable iff (!arst_n)
		busy |-> status == 8'hFF)
		else $error("status not all ones while busy");

	// the end of a write leaves programming disabled
	chk_latch_reset: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$fell(busy) |=> !latch_ff)
		else $error("latch not cleared after write");

	// the output floats once select has been high for two samples
	chk_float_desel: assert property (@(posedge ref_clk) disable iff (!arst_n)
		sync_ff.cs_n [*2] |-> so_oe_n)
		else $error("output driven while deselected");

	// programming starts only at a select rising edge
	chk_start_edge: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(busy) |-> $past(cs_rise))
		else $error("write began without select rise");

	// latch set is refused while the protect pin is low
	chk_wp_blocks_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_set_while_wp |=> $stable(latch_ff))
		else $error("latch changed while protect pin low");

	// latch clear on an idle device always takes effect
	chk_clear_latch: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_clear_op |=> !latch_ff)
		else $error("latch still set after clear");

	// a busy device drops every opcode except the status read
	chk_busy_ignore: assert property (@(posedge ref_clk) disable iff (!arst_n)
		s_op_while_busy |=> ph_ff == SEC_DEAD)
		else $error("opcode honoured during write cycle");

	// a dead frame never drives the output
	chk_dead_float: assert property (@(posedge ref_clk) disable iff (!arst_n)
		ph_ff == SEC_DEAD |=> so_oe_n)
		else $error("output driven after undefined opcode");

	// hold floats the output
	chk_hold_float: assert property (@(posedge ref_clk) disable iff (!arst_n)
		hold_ff |=> so_oe_n)
		else $error("output driven during hold");

	// the write cycle lasts exactly the configured count
	chk_write_length: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$fell(busy) |-> busy_cnt_ff == 32'(WRITE_CYC))
		else $error("write cycle length differs from setting");
endmodule
`default_nettype wire

// ===== verif/sec_master.sv
// spi master model that drives the eeprom pins
`timescale 1ns/1ps
`default_nettype none
module sec_master import sec_pkg::*; (
	input  wire logic      ref_clk,
	output var  sec_pins_s pins,
	input  wire logic      so_out,
	input  wire logic      so_oe_n
);
	logic drove;
	initial begin
		pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
		drove = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wp(input logic v);
		tick(1);
		pins.wp_n <= v;
	endtask
	// select only moves in the clock-low phase; si scrambles so no stale bit lingers
	task automatic sel(input logic on);
		tick(4);
		pins.cs_n <= !on;
		pins.si   <= !pins.si;
		drove = 1'b0;
		tick(4);
	endtask
	// hold moves only while the link clock is low
	task automatic hold(input logic v);
		tick(2);
		pins.hold_n <= v;
		tick(6);
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			pins.sck <= 1'b0;
			pins.si  <= tx[i];
			tick(4);
			pins.sck <= 1'b1;
			tick(3);
			rx[i] = so_out;
			if (so_oe_n === 1'b0) drove = 1'b1;
			tick(1);
		end
		pins.sck <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the serial eeprom command logic
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sec_pkg::*;
	localparam int WCYC = 400;
	logic       ref_clk;
	logic       arst_n;
	sec_pins_s  pins;
	logic       so_out;
	logic       so_oe_n;
	logic       busy;
	logic [7:0] rx;
	int         miscompares;
	int         checked;
	sec_eeprom #(.WRITE_CYC(WCYC)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins),
		.so_out(so_out), .so_oe_n(so_oe_n), .busy(busy));
	sec_master mst_u (.ref_clk(ref_clk), .pins(pins), .so_out(so_out), .so_oe_n(so_oe_n));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic frame(input logic [7:0] tx[$], output logic [7:0] r[$]);
		mst_u.sel(1'b1);
		r = {};
		foreach (tx[i]) begin
			mst_u.xfer(tx[i], rx);
			r.push_back(rx);
		end
		mst_u.sel(1'b0);
	endtask
	task automatic stat(input logic [7:0] op, input logic [7:0] exp);
		logic [7:0] r[$];
		frame({op, 8'h00}, r);
		check("status", r[1], exp);
	endtask
	// busy may rise a few cycles after select; the wait is bounded
	task automatic settle();
		mst_u.tick(8);
		for (int i = 0; i < 4 * WCYC && busy !== 1'b0; i++) @(posedge ref_clk);
		check("busy", {7'h00, busy}, 8'h00);
	endtask
	initial begin
		logic [7:0] q[$];
		logic [7:0] r[$];
		miscompares = 0;
		checked = 0;
		arst_n = 1'b0;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		mst_u.tick(4);
		stat(8'h05, 8'h00);
		for (int i = 0; i < 2; i++) begin
			frame({i ? 8'h0E : 8'h06}, r);
			stat(i ? 8'h0D : 8'h05, 8'h02);
			frame({i ? 8'h0C : 8'h04}, r);
			stat(8'h05, 8'h00);
		end
		mst_u.wp(1'b0);
		frame({8'h06}, r);
		stat(8'h05, 8'h00);
		mst_u.wp(1'b1);
		frame({8'h06}, r);
		mst_u.wp(1'b0);
		frame({8'h04}, r);
		mst_u.wp(1'b1);
		stat(8'h05, 8'h00);
		frame({8'h02, 8'h00, 8'hA5}, r);
		stat(8'h05, 8'h00);
		frame({8'h06}, r);
		frame({8'h02, 8'h00, 8'h5A}, r);
		settle();
		frame({8'h06}, r);
		q = {8'h0A, 8'hF8};
		for (int i = 0; i < 9; i++) q.push_back(8'h10 + 8'(i));
		frame(q, r);
		stat(8'h0D, 8'hFF);
		frame({8'h02, 8'h00, 8'hEE}, r);
		settle();
		stat(8'h05, 8'h00);
		frame({8'h0B, 8'hFE, 8'h00, 8'h00, 8'h00}, r);
		check("rd1fe", r[2], 8'h16);
		check("rd1ff", r[3], 8'h17);
		check("rd000", r[4], 8'h5A);
		mst_u.sel(1'b1);
		mst_u.xfer(8'h0B, rx);
		mst_u.xfer(8'hFE, rx);
		mst_u.hold(1'b0);
		check("oe_hold", {7'h00, so_oe_n}, 8'h01);
		mst_u.xfer(8'h00, rx);
		mst_u.hold(1'b1);
		mst_u.xfer(8'h00, rx);
		check("rd_hold", rx, 8'h16);
		mst_u.sel(1'b0);
		frame({8'h06}, r);
		mst_u.sel(1'b1);
		mst_u.xfer(8'h02, rx);
		mst_u.xfer(8'h00, rx);
		mst_u.xfer(8'h77, rx);
		mst_u.wp(1'b0);
		mst_u.sel(1'b0);
		mst_u.wp(1'b1);
		check("busy_wp", {7'h00, busy}, 8'h00);
		frame({8'h03, 8'h00, 8'h00}, r);
		check("rd000_wp", r[2], 8'h5A);
		frame({8'h06}, r);
		frame({8'h01, 8'h04}, r);
		settle();
		stat(8'h05, 8'h04);
		frame({8'h06}, r);
		frame({8'h0A, 8'hF8, 8'h00}, r);
		settle();
		frame({8'h0B, 8'hF8, 8'h00}, r);
		check("rd1f8", r[2], 8'h18);
		frame({8'hFF, 8'h00}, r);
		check("drove", {7'h00, mst_u.drove}, 8'h00);
		check("oe_n", {7'h00, so_oe_n}, 8'h01);
		print_verdict();
	end
	initial begin
		#1000000;
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
